// ### hw/cmp_unit.sv
module cmp_unit
  import cntarr_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // Shared counter state and register writes
  input  wire cnt_state_s cnt_in,
  input  wire cmp_wr_s    wr_in,
  // Module state
  output cmp_mode_s       mode_out,
  output logic [7:0]      low_out,
  output logic [7:0]      high_out,
  output logic            pin_out,
  output logic            match_out
);

  cmp_mode_s  mode_ff;
  logic [7:0] low_ff;
  logic [7:0] high_ff;
  logic       pin_ff;

  cmp_mode_s  nxt_mode;
  logic [7:0] nxt_low;
  logic [7:0] nxt_high;
  logic       nxt_pin;

  wire        cmp_mode  = mode_ff.ecom & mode_ff.mat & ~mode_ff.pwm;
  wire        pwm_mode  = mode_ff.ecom & mode_ff.pwm & cnt_in.pwm8;
  wire [7:0]  next_low  = 8'(cnt_in.count[7:0] + 8'h01);
  wire        cmp_hit   = cmp_mode & (cnt_in.count == {high_ff, low_ff});
  // Pin is aligned with the counter value it belongs to, so look one count ahead
  wire        rise_wrap = cnt_in.low_wrap & (high_ff == RST_BYTE);
  wire        rise_step = cnt_in.run & ~cnt_in.low_wrap & (next_low == low_ff);
  wire        pwm_set   = pwm_mode & (rise_wrap | rise_step);

  assign match_out = cmp_hit | (pwm_set & mode_ff.mat & ~pin_ff);
  assign mode_out  = mode_ff;
  assign low_out   = low_ff;
  assign high_out  = high_ff;
  assign pin_out   = pin_ff;

  always_comb begin
    nxt_mode = mode_ff;
    if (wr_in.wr_mode) begin
      nxt_mode.ecom = wr_in.data[MODE_ECOM_BIT];
      nxt_mode.mat  = wr_in.data[MODE_MAT_BIT];
      nxt_mode.pwm  = wr_in.data[MODE_PWM_BIT];
    end
    if (wr_in.wr_low) begin
      nxt_mode.ecom = 1'b0;
    end
    if (wr_in.wr_high) begin
      nxt_mode.ecom = 1'b1;
    end
  end

  // Software write beats the automatic reload in the same cycle
  assign nxt_low  = wr_in.wr_low ? wr_in.data :
                    (pwm_mode & cnt_in.low_wrap) ? high_ff : low_ff;
  assign nxt_high = wr_in.wr_high ? wr_in.data : high_ff;

  always_comb begin
    if (!pwm_mode) begin
      nxt_pin = 1'b0;
    end else if (pwm_set) begin
      nxt_pin = 1'b1;
    end else if (cnt_in.low_wrap) begin
      nxt_pin = 1'b0;
    end else begin
      nxt_pin = pin_ff;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mode_ff <= '0;
      low_ff  <= RST_BYTE;
      high_ff <= RST_BYTE;
      pin_ff  <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      low_ff  <= nxt_low;
      high_ff <= nxt_high;
      pin_ff  <= nxt_pin;
    end
  end

endmodule

// ### hw/cntarr_pkg.sv
package cntarr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PWMCFG   = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 12'h014;
  localparam logic [ADDR_W-1:0] MOD_BASE     = 12'h020;
  localparam logic [ADDR_W-1:0] MOD_STRIDE   = 12'h010;
  localparam logic [ADDR_W-1:0] MOD_MODE_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] MOD_LOW_OFS  = 12'h004;
  localparam logic [ADDR_W-1:0] MOD_HIGH_OFS = 12'h008;

  // Field positions
  localparam int CTRL_COV_BIT   = 7;
  localparam int CTRL_RUN_BIT   = 6;
  localparam int PWMCFG_POV_BIT = 7;
  localparam int PWMCFG_WID_LSB = 0;
  localparam int STAT_COV_BIT   = 7;
  localparam int STAT_POV_BIT   = 6;
  localparam int MODE_ECOM_BIT  = 6;
  localparam int MODE_MAT_BIT   = 3;
  localparam int MODE_PWM_BIT   = 1;
  localparam int MAX_MODULES    = 6;

  // Encodings, reset values and counts
  localparam logic [1:0]       PWM_WIDTH_8 = 2'h0;
  localparam logic [7:0]       RST_BYTE    = 8'h00;
  localparam logic [CNT_W-1:0] RST_COUNT   = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_MAX   = 16'hffff;
  localparam logic [7:0]       LOW_MAX     = 8'hff;
  localparam int               PWM8_PERIOD = 256;

  typedef struct packed {
    logic ecom;
    logic mat;
    logic pwm;
  } cmp_mode_s;

  typedef struct packed {
    logic       wr_mode;
    logic       wr_low;
    logic       wr_high;
    logic [7:0] data;
  } cmp_wr_s;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             run;
    logic             low_wrap;
    logic             pwm8;
  } cnt_state_s;

endpackage

// ### hw/counter_array_compare_pwm.sv
module counter_array_compare_pwm
  import cntarr_pkg::*;
#(
  parameter int NUM_MODULES = 3
) (
  // Clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   sys_rst_in,
  // APB slave
  input  wire logic                   apb_psel_in,
  input  wire logic                   apb_penable_in,
  input  wire logic                   apb_pwrite_in,
  input  wire logic [ADDR_W-1:0]      apb_paddr_in,
  input  wire logic [DATA_W-1:0]      apb_pwdata_in,
  output logic      [DATA_W-1:0]      apb_prdata_out,
  output logic                        apb_pready_out,
  output logic                        apb_pslverr_out,
  // Module output pins and interrupt
  output logic      [NUM_MODULES-1:0] module_output_pin_out,
  output logic                        irq_out
);

  if (NUM_MODULES < 1 || NUM_MODULES > MAX_MODULES) begin : g_bad_count
    $error("NUM_MODULES must be between 1 and 6");
  end

  logic [CNT_W-1:0]       count_ff;
  logic                   counter_run_ff;
  logic [1:0]             pwm_width_select_ff;
  logic                   counter_overflow_flag_ff;
  logic                   pwm_overflow_flag_ff;
  logic [NUM_MODULES-1:0] module_match_flag_ff;
  logic [7:0]             irq_enable_ff;
  logic [DATA_W-1:0]      prdata_ff;
  logic                   pslverr_ff;

  logic [CNT_W-1:0]       nxt_count;
  logic [NUM_MODULES-1:0] nxt_match_flag;
  logic                   nxt_cov_flag;
  logic                   nxt_pov_flag;
  logic [DATA_W-1:0]      rd_mux;
  logic [7:0]             irq_status;

  // Per-module wires
  cmp_mode_s              mode_w   [NUM_MODULES];
  logic [7:0]             low_w    [NUM_MODULES];
  logic [7:0]             high_w   [NUM_MODULES];
  logic [7:0]             mode_byte[NUM_MODULES];
  cmp_wr_s                wr_w     [NUM_MODULES];
  logic [NUM_MODULES-1:0] match_w;
  logic [NUM_MODULES-1:0] pin_w;
  logic [NUM_MODULES-1:0] hit_mode;
  logic [NUM_MODULES-1:0] hit_low;
  logic [NUM_MODULES-1:0] hit_high;
  logic [NUM_MODULES-1:0] match_clr;
  cnt_state_s             cnt;

  // APB decode
  wire apb_setup  = apb_psel_in & ~apb_penable_in;
  wire apb_access = apb_psel_in & apb_penable_in;
  wire hit_ctrl   = (apb_paddr_in == OFS_CTRL);
  wire hit_pcfg   = (apb_paddr_in == OFS_PWMCFG);
  wire hit_count  = (apb_paddr_in == OFS_COUNT);
  wire hit_istat  = (apb_paddr_in == OFS_IRQ_STAT);
  wire hit_iclr   = (apb_paddr_in == OFS_IRQ_CLR);
  wire hit_ien    = (apb_paddr_in == OFS_IRQ_EN);
  wire mapped     = hit_ctrl | hit_pcfg | hit_count | hit_istat | hit_iclr | hit_ien |
                    (|hit_mode) | (|hit_low) | (|hit_high);
  wire wr_acc     = apb_access & apb_pwrite_in & mapped;
  wire wr_ctrl    = wr_acc & hit_ctrl;
  wire wr_pcfg    = wr_acc & hit_pcfg;
  wire wr_iclr    = wr_acc & hit_iclr;
  wire wr_ien     = wr_acc & hit_ien;
  wire [7:0] wbyte = apb_pwdata_in[7:0];

  // Counter events
  wire low_wrap   = counter_run_ff & (count_ff[7:0] == LOW_MAX);
  wire full_wrap  = counter_run_ff & (count_ff == COUNT_MAX);
  wire pwm8       = (pwm_width_select_ff == PWM_WIDTH_8);

  assign nxt_count = counter_run_ff ? 16'(count_ff + 16'h0001) : count_ff;
  assign cnt       = '{count: count_ff, run: counter_run_ff, low_wrap: low_wrap, pwm8: pwm8};

  // Sticky flags: hardware set wins over any clear in the same cycle
  wire cov_clr = (wr_ctrl & ~wbyte[CTRL_COV_BIT]) | (wr_iclr & wbyte[STAT_COV_BIT]);
  wire pov_clr = (wr_pcfg & ~wbyte[PWMCFG_POV_BIT]) | (wr_iclr & wbyte[STAT_POV_BIT]);
  assign nxt_cov_flag   = full_wrap | (counter_overflow_flag_ff & ~cov_clr);
  assign nxt_pov_flag   = low_wrap | (pwm_overflow_flag_ff & ~pov_clr);
  assign nxt_match_flag = match_w | (module_match_flag_ff & ~match_clr);

  for (genvar n = 0; n < NUM_MODULES; n++) begin : g_mod
    localparam logic [ADDR_W-1:0] MADDR = 12'(MOD_BASE + 12'(n) * MOD_STRIDE);

    assign hit_mode[n]  = (apb_paddr_in == 12'(MADDR + MOD_MODE_OFS));
    assign hit_low[n]   = (apb_paddr_in == 12'(MADDR + MOD_LOW_OFS));
    assign hit_high[n]  = (apb_paddr_in == 12'(MADDR + MOD_HIGH_OFS));
    // Clear by writing zero to the control bit, or one to the clear register
    assign match_clr[n] = (wr_ctrl & ~wbyte[n]) | (wr_iclr & wbyte[n]);
    assign wr_w[n]      = '{wr_mode: wr_acc & hit_mode[n], wr_low: wr_acc & hit_low[n],
                            wr_high: wr_acc & hit_high[n], data: wbyte};
    assign mode_byte[n] = (8'(mode_w[n].ecom) << MODE_ECOM_BIT) |
                          (8'(mode_w[n].mat) << MODE_MAT_BIT) |
                          (8'(mode_w[n].pwm) << MODE_PWM_BIT);

    cmp_unit u_cmp (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .cnt_in     (cnt),
      .wr_in      (wr_w[n]),
      .mode_out   (mode_w[n]),
      .low_out    (low_w[n]),
      .high_out   (high_w[n]),
      .pin_out    (pin_w[n]),
      .match_out  (match_w[n])
    );

    wire pwm_act = mode_w[n].ecom & mode_w[n].pwm & pwm8;

    a_cmp_sets_flag: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_w[n].ecom && mode_w[n].mat && !mode_w[n].pwm &&
       count_ff == {high_w[n], low_w[n]}) |=> module_match_flag_ff[n])
      else $error("compare match did not set module flag");

    a_flag_sticky: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (module_match_flag_ff[n] && !match_clr[n]) |=> module_match_flag_ff[n])
      else $error("module flag dropped without software clear");

    a_low_wr_ecom: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (wr_acc && hit_low[n]) |=> (!mode_w[n].ecom && low_w[n] == $past(wbyte)))
      else $error("low byte write did not clear comparator enable");

    a_high_wr_ecom: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (wr_acc && hit_high[n]) |=> mode_w[n].ecom)
      else $error("high byte write did not set comparator enable");

    a_pwm_rise: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (pwm_act && counter_run_ff && !low_wrap &&
       8'(count_ff[7:0] + 8'h01) == low_w[n]) |=> pin_w[n])
      else $error("pwm pin not set on low byte match");

    a_pwm_fall: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (pwm_act && low_wrap && high_w[n] != RST_BYTE) |=> !pin_w[n])
      else $error("pwm pin not cleared on low byte overflow");

    a_pwm_reload: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (pwm_act && low_wrap && !(wr_acc && hit_low[n])) |=> low_w[n] == $past(high_w[n]))
      else $error("low compare byte not reloaded from high byte");

    a_pwm_zero_duty: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_w[n].pwm && !mode_w[n].ecom) |=> !pin_w[n])
      else $error("pwm pin high with comparator disabled");

    a_pwm_full_duty: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (pwm_act && pin_w[n] && high_w[n] == RST_BYTE && low_w[n] == RST_BYTE &&
       !wr_acc) |=> pin_w[n])
      else $error("pwm pin fell with zero high byte");

    a_pwm_edge_flag: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      ($past(mode_w[n].mat) && $rose(pin_w[n])) |-> module_match_flag_ff[n])
      else $error("pwm rising edge did not set module flag");
  end

  // Interrupt status layout: counter wrap, pwm wrap, module matches
  always_comb begin
    irq_status                 = 8'h00;
    irq_status[NUM_MODULES-1:0] = module_match_flag_ff;
    irq_status[STAT_POV_BIT]    = pwm_overflow_flag_ff;
    irq_status[STAT_COV_BIT]    = counter_overflow_flag_ff;
  end

  assign irq_out = |(irq_status & irq_enable_ff);

  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux[NUM_MODULES-1:0] = module_match_flag_ff;
      rd_mux[CTRL_RUN_BIT]    = counter_run_ff;
      rd_mux[CTRL_COV_BIT]    = counter_overflow_flag_ff;
    end
    if (hit_pcfg) begin
      rd_mux[PWMCFG_WID_LSB +: 2] = pwm_width_select_ff;
      rd_mux[PWMCFG_POV_BIT]      = pwm_overflow_flag_ff;
    end
    if (hit_count) begin
      rd_mux[CNT_W-1:0] = count_ff;
    end
    if (hit_istat) begin
      rd_mux[7:0] = irq_status;
    end
    if (hit_ien) begin
      rd_mux[7:0] = irq_enable_ff;
    end
    for (int i = 0; i < NUM_MODULES; i++) begin
      if (hit_mode[i]) begin
        rd_mux[7:0] = mode_byte[i];
      end
      if (hit_low[i]) begin
        rd_mux[7:0] = low_w[i];
      end
      if (hit_high[i]) begin
        rd_mux[7:0] = high_w[i];
      end
    end
  end

  // Read data latched in setup so the access phase sees a stable register
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      prdata_ff  <= apb_pwrite_in ? '0 : rd_mux;
      pslverr_ff <= ~mapped;
    end
  end

  assign apb_prdata_out        = prdata_ff;
  assign apb_pready_out        = 1'b1;
  assign apb_pslverr_out       = pslverr_ff & apb_access;
  assign module_output_pin_out = pin_w;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      count_ff                 <= RST_COUNT;
      counter_run_ff           <= 1'b0;
      pwm_width_select_ff      <= PWM_WIDTH_8;
      counter_overflow_flag_ff <= 1'b0;
      pwm_overflow_flag_ff     <= 1'b0;
      module_match_flag_ff     <= '0;
      irq_enable_ff            <= 8'h00;
    end else begin
      count_ff                 <= nxt_count;
      counter_overflow_flag_ff <= nxt_cov_flag;
      pwm_overflow_flag_ff     <= nxt_pov_flag;
      module_match_flag_ff     <= nxt_match_flag;
      if (wr_ctrl) begin
        counter_run_ff <= wbyte[CTRL_RUN_BIT];
      end
      if (wr_pcfg) begin
        pwm_width_select_ff <= wbyte[PWMCFG_WID_LSB +: 2];
      end
      if (wr_ien) begin
        irq_enable_ff <= wbyte;
      end
    end
  end

  a_run_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !counter_run_ff |=> $stable(count_ff))
    else $error("counter moved while stopped");

  a_ovf_wrap: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    full_wrap |=> (count_ff == RST_COUNT && counter_overflow_flag_ff))
    else $error("counter wrap did not set overflow flag");

  a_ovf_irq: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (full_wrap && irq_enable_ff[STAT_COV_BIT] && !wr_ien) |=> irq_out)
    else $error("enabled overflow did not raise interrupt");

  a_pov_period: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (low_wrap && !pov_clr) ##1 (counter_run_ff && !pov_clr)[*8] |-> pwm_overflow_flag_ff)
    else $error("low byte overflow did not set pwm overflow flag");

  a_reset_clean: assert property (@(posedge sys_clk_in)
    sys_rst_in |=> (module_output_pin_out == '0 && module_match_flag_ff == '0 &&
                    !counter_overflow_flag_ff && !pwm_overflow_flag_ff && !irq_out))
    else $error("state not clean after reset");

endmodule

// ### verif/counter_array_compare_pwm_bench.sv
module counter_array_compare_pwm_bench;
  import cntarr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int NMOD  = 3;
  localparam int LIMIT = 95000;

  logic              sys_clk_in;
  logic              sys_rst_in;
  logic              apb_psel_in;
  logic              apb_penable_in;
  logic              apb_pwrite_in;
  logic [ADDR_W-1:0] apb_paddr_in;
  logic [DATA_W-1:0] apb_pwdata_in;
  logic [DATA_W-1:0] apb_prdata_out;
  logic              apb_pready_out;
  logic              apb_pslverr_out;
  logic [NMOD-1:0]   module_output_pin_out;
  logic              irq_out;
  logic [DATA_W-1:0] rd;
  logic              er;
  logic [15:0]       seed;
  logic [15:0]       v;
  logic [15:0]       c1;
  logic [7:0]        h;
  int                n_errors;
  int                n_compared;
  int                cycles;
  int                hi;

  counter_array_compare_pwm #(.NUM_MODULES(NMOD)) u_dut (
    .sys_clk_in            (sys_clk_in),
    .sys_rst_in            (sys_rst_in),
    .apb_psel_in           (apb_psel_in),
    .apb_penable_in        (apb_penable_in),
    .apb_pwrite_in         (apb_pwrite_in),
    .apb_paddr_in          (apb_paddr_in),
    .apb_pwdata_in         (apb_pwdata_in),
    .apb_prdata_out        (apb_prdata_out),
    .apb_pready_out        (apb_pready_out),
    .apb_pslverr_out       (apb_pslverr_out),
    .module_output_pin_out (module_output_pin_out),
    .irq_out               (irq_out)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [ADDR_W-1:0] maddr(input int n, input logic [ADDR_W-1:0] ofs);
    return MOD_BASE + MOD_STRIDE * n[ADDR_W-1:0] + ofs;
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Zero-wait slave still waits on pready; only the bench timeout ends a hang
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    apb_psel_in    <= 1'b1;
    apb_penable_in <= 1'b0;
    apb_pwrite_in  <= wr;
    apb_paddr_in   <= a;
    apb_pwdata_in  <= d;
    @(posedge sys_clk_in);
    apb_penable_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
    end while (apb_pready_out !== 1'b1);
    rd = apb_prdata_out;
    er = apb_pslverr_out;
    apb_psel_in    <= 1'b0;
    apb_penable_in <= 1'b0;
  endtask

  // Settles past one reload period, clears match flags (run kept), counts two periods
  task automatic count_high(input int idx);
    repeat (300) @(posedge sys_clk_in);
    apb(1, OFS_CTRL, 32'h40);
    hi = 0;
    repeat (2 * PWM8_PERIOD) begin
      @(posedge sys_clk_in);
      if (module_output_pin_out[idx] === 1'b1) hi++;
    end
  endtask

  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    sys_rst_in = 1'b1;
    apb_psel_in = 1'b0;
    apb_penable_in = 1'b0;
    apb_pwrite_in = 1'b0;
    apb_paddr_in = '0;
    apb_pwdata_in = '0;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    seed = 16'h2fb9;
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;

    for (int i = 0; i < NMOD; i++) begin
      check("pin_rst", 0, module_output_pin_out[i]);
    end
    check("irq_rst", 0, irq_out);
    for (int n = 0; n < NMOD; n++) begin
      apb(0, maddr(n, MOD_MODE_OFS), 0);
      check("mode_rst", 0, rd);
    end
    apb(0, OFS_CTRL, 0);
    check("ctrl_rst", 0, rd);
    apb(0, OFS_PWMCFG, 0);
    check("pwmcfg_rst", 0, rd);
    apb(0, 12'hffc, 0);
    check("unmapped_rd", 32'h1, {rd[30:0], er});
    apb(1, 12'hffc, 32'hff);
    check("unmapped_wr", 1, er);
    $display("test reset_and_map done");

    seed = lfsr_next(seed);
    v = 16'h0100 + {5'h00, seed[10:0]};
    apb(1, maddr(0, MOD_MODE_OFS), 32'h48);
    apb(1, maddr(0, MOD_LOW_OFS), {24'h0, v[7:0]});
    apb(0, maddr(0, MOD_MODE_OFS), 0);
    check("ecom_after_low", 0, rd[MODE_ECOM_BIT]);
    apb(1, maddr(0, MOD_HIGH_OFS), {24'h0, v[15:8]});
    apb(0, maddr(0, MOD_MODE_OFS), 0);
    check("ecom_after_high", 1, rd[MODE_ECOM_BIT]);
    apb(1, OFS_IRQ_EN, 32'h1);
    apb(1, OFS_CTRL, 32'h40);
    for (int k = 0; k < 1200; k++) begin
      apb(0, OFS_IRQ_STAT, 0);
      if (rd[0] === 1'b1) break;
    end
    apb(0, OFS_COUNT, 0);
    c1 = rd[15:0] - v;
    check("match_lag_ok", 1, c1 >= 16'h1 && c1 <= 16'hc);
    @(posedge sys_clk_in);
    check("irq_match", 1, irq_out);
    apb(1, OFS_IRQ_EN, 32'h0);
    @(posedge sys_clk_in);
    check("irq_masked", 0, irq_out);
    apb(1, OFS_IRQ_EN, 32'h1);
    apb(0, OFS_CTRL, 0);
    check("flag_sticky", 1, rd[0]);
    apb(1, OFS_CTRL, 32'h40);
    apb(0, OFS_CTRL, 0);
    check("flag_cleared", 0, rd[0]);
    apb(1, OFS_CTRL, 32'h0);
    apb(0, OFS_COUNT, 0);
    c1 = rd[15:0];
    repeat (20) @(posedge sys_clk_in);
    apb(0, OFS_COUNT, 0);
    check("count_held", {16'h0, c1}, rd);
    $display("test compare_mode done");

    for (int t = 0; t < 6; t++) begin
      seed = lfsr_next(seed);
      h = (t == 0) ? 8'h00 : (t == 1) ? 8'hff : (t == 2) ? 8'h80 : seed[7:0];
      apb(1, maddr(1, MOD_MODE_OFS), 32'h4a);
      apb(1, maddr(1, MOD_LOW_OFS), {24'h0, seed[15:8]});
      apb(1, maddr(1, MOD_HIGH_OFS), {24'h0, h});
      apb(1, OFS_CTRL, 32'h40);
      apb(1, OFS_PWMCFG, 32'h0);
      count_high(1);
      check("pwm_high_cycles", 2 * (PWM8_PERIOD - h), hi);
      apb(0, OFS_CTRL, 0);
      check("pwm_match_flag", h != 8'h00, rd[1]);
      apb(0, OFS_PWMCFG, 0);
      check("pwm_ovf_flag", 1, rd[PWMCFG_POV_BIT]);
    end
    apb(1, maddr(1, MOD_LOW_OFS), 32'h0);
    count_high(1);
    check("pwm_ecom_off", 0, hi);
    apb(1, maddr(1, MOD_HIGH_OFS), 32'h0);
    for (int w = 1; w < 4; w++) begin
      apb(1, OFS_PWMCFG, w);
      count_high(1);
      check("pwm_width_off", 0, hi);
    end
    $display("test pwm8 done");

    apb(1, OFS_CTRL, 32'h40);
    for (int k = 0; k < 30000; k++) begin
      apb(0, OFS_CTRL, 0);
      if (rd[CTRL_COV_BIT] === 1'b1) break;
    end
    apb(0, OFS_COUNT, 0);
    check("wrap_lag_ok", 1, rd[15:0] < 16'h0010);
    apb(1, OFS_IRQ_EN, 32'h80);
    @(posedge sys_clk_in);
    check("irq_ovf", 1, irq_out);
    apb(1, OFS_IRQ_CLR, 32'h80);
    apb(0, OFS_IRQ_STAT, 0);
    check("ovf_cleared", 0, rd[STAT_COV_BIT]);
    apb(0, OFS_IRQ_CLR, 0);
    check("clr_reads_zero", 0, rd);
    @(posedge sys_clk_in);
    check("irq_ovf_off", 0, irq_out);
    $display("test overflow done");
    complete_run();
  end
endmodule
